// ### rtl/switch_port_current_control.sv
// Eight-channel switch interface control: configuration, gating, thermal, status
// Function
// - Only channels one to three may become low-side sinks.
// - Direction bit resets to 0 (source); 1 selects sink on channels one to three.
// - Current-halve bit at 1 halves output current, ratio 100 down to 50.
// - Enabled channel with direct-on 1 stays on; with 0 its gate input switches it.
// - Output off when disabled, or gated with gate low; otherwise on.
// - Low-power mode allowed only while every channel output is off.
// - Gate one drives 1,7,8; gate two drives 2,5,6; gate three drives 3,4.
// - One slope-disable bit for all outputs; 1 removes transition times.
// - Three-bit address equals channel number minus one.
// - Program-enable 1 loads enable, direction, irq-enable, direct-on into addressed channel.
// - Slope-disable changes only on words with program-enable 0, no channel bits then.
// - Any overtemperature turns all outputs off and raises an interrupt.
// - Thermal shutdown keeps enable bits; outputs resume after cooling.
// - Each channel's debounced comparator state is readable in the status word.
// - Outputs drive only in active mode.
// - A switch state change can wake the system from low-power mode.
// - Shared bit is irq-enable with program-enable 1, slope-disable with 0.
// - Comparator sampled at gate or direct-on fall; change raises enabled interrupt.
// - Gate rise in low-power mode with enabled gated channels requests active mode.
// - Change interrupt source code clears after the host reads the status word.
`timescale 1ns/1ps
module switch_port_current_control
  import switch_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire cmd_word_t cmd_word,
  input wire logic status_read,
  input wire logic gate_input_one,
  input wire logic gate_input_two,
  input wire logic gate_input_three,
  input wire logic [CHANNELS-1:0] comparator_in,
  input wire logic [CHANNELS-1:0] overtemp_in,
  input wire logic active_mode,
  input wire logic low_power_mode,
  output logic [CHANNELS-1:0] source_on,
  output logic [CHANNELS-1:0] sink_mode,
  output logic slope_disable,
  output logic current_halve,
  output logic low_power_permitted,
  output logic wake_request,
  output status_word_t status_word,
  output logic irq_out_n
);
  localparam int SYNC_WIDTH = 3 + 2 * CHANNELS;

  logic [SYNC_WIDTH-1:0] sync_in;
  logic [SYNC_WIDTH-1:0] sync_out;
  logic [2:0] gate_level;
  logic [2:0] gate_prev_reg;
  logic [2:0] gate_rise;
  logic [CHANNELS-1:0] comparator_level;
  logic [CHANNELS-1:0] overtemp_level;
  logic overtemp_any;
  logic drive_allowed;

  logic [CHANNELS-1:0] enable_reg;
  logic [CHANNELS-1:0] direct_reg;
  logic [CHANNELS-1:0] sink_reg;
  logic [CHANNELS-1:0] irq_en_reg;
  logic [CHANNELS-1:0] addr_hit;
  logic [CHANNELS-1:0] load_chan;
  logic load_global;
  logic slope_reg;
  logic halve_reg;

  logic [CHANNELS-1:0] chan_gate;
  logic [CHANNELS-1:0] chan_off;
  logic [CHANNELS-1:0] chan_change;
  logic change_irq;
  logic [1:0] code_reg;
  logic [1:0] code_next;
  logic ot_pend_reg;
  logic ot_pend_next;
  logic ot_prev_reg;
  logic ot_rise;
  logic [CHANNELS-1:0] gated_ready;
  logic wake_gate;
  logic wake_reg;
  status_word_t status_reg;

  // All pin-side inputs pass one shared synchroniser
  assign sync_in = {overtemp_in, comparator_in, gate_input_three, gate_input_two,
                    gate_input_one};
  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(sync_in),
    .level_out(sync_out)
  );
  assign gate_level = sync_out[2:0];
  assign comparator_level = sync_out[3 +: CHANNELS];
  assign overtemp_level = sync_out[3 + CHANNELS +: CHANNELS];

  // Any monitor over threshold shuts every source, config untouched
  assign overtemp_any = |overtemp_level;
  assign drive_allowed = active_mode & ~overtemp_any;

  // Fixed gate-to-channel wiring
  assign chan_gate[0] = gate_level[0];
  assign chan_gate[1] = gate_level[1];
  assign chan_gate[2] = gate_level[2];
  assign chan_gate[3] = gate_level[2];
  assign chan_gate[4] = gate_level[1];
  assign chan_gate[5] = gate_level[1];
  assign chan_gate[6] = gate_level[0];
  assign chan_gate[7] = gate_level[0];

  // Address decode: binary value is channel number minus one
  assign addr_hit = CHANNELS'(1) << cmd_word.channel_addr;
  assign load_chan = (cmd_valid & cmd_word.channel_program_enable) ? addr_hit : '0;
  assign load_global = cmd_valid & ~cmd_word.channel_program_enable;

  // Channel configuration loads only for the addressed channel
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_reg <= RESET_BYTE;
      direct_reg <= RESET_BYTE;
      sink_reg <= RESET_BYTE;
      irq_en_reg <= RESET_BYTE;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (load_chan[i]) begin
          enable_reg[i] <= cmd_word.source_enable;
          direct_reg[i] <= cmd_word.source_direct_on;
          sink_reg[i] <= cmd_word.sink_select;
          irq_en_reg[i] <= cmd_word.irq_or_slope;
        end
      end
    end
  end

  // Global bits; halve goes with every word since it has no address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slope_reg <= RESET_LOW;
      halve_reg <= RESET_LOW;
    end else begin
      if (load_global) begin
        slope_reg <= cmd_word.irq_or_slope;
      end
      if (cmd_valid) begin
        halve_reg <= cmd_word.current_halve;
      end
    end
  end
  assign slope_disable = slope_reg;
  assign current_halve = halve_reg;

  // Direction only reaches the three sink-capable channels
  assign sink_mode = sink_reg & {5'h00, SINK_CAPABLE_MASK};

  // Per-channel drive and state-change logic
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    chan_cfg_t cfg;
    assign cfg = '{source_enable: enable_reg[c], source_direct_on: direct_reg[c],
                   sink_select: sink_reg[c], channel_irq_enable: irq_en_reg[c]};
    switch_channel u_channel (
      .core_clk(core_clk),
      .rst(rst),
      .cfg(cfg),
      .gate_level(chan_gate[c]),
      .comparator_level(comparator_level[c]),
      .drive_allowed(drive_allowed),
      .source_on(source_on[c]),
      .output_off(chan_off[c]),
      .state_change(chan_change[c])
    );
  end

  // Low power allowed only with every source idle
  assign low_power_permitted = &chan_off;

  // Interrupt events; a new event wins over a clearing read
  assign change_irq = |(chan_change & irq_en_reg);
  assign ot_rise = overtemp_any & ~ot_prev_reg;
  assign code_next = change_irq ? IRQ_CODE_CHANGE :
                     (status_read ? IRQ_CODE_NONE : code_reg);
  assign ot_pend_next = ot_rise | (ot_pend_reg & ~status_read);

  // Interrupt state; reset leaves the request line released
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_reg <= IRQ_CODE_NONE;
      ot_pend_reg <= RESET_LOW;
      ot_prev_reg <= RESET_LOW;
    end else begin
      code_reg <= code_next;
      ot_pend_reg <= ot_pend_next;
      ot_prev_reg <= overtemp_any;
    end
  end
  // Request stays low while a change code or an overtemp is pending
  assign irq_out_n = ~((code_reg == IRQ_CODE_CHANGE) | ot_pend_reg);

  // Wake: gate rise onto enabled gated channels, or an enabled change
  assign gate_rise = gate_level & ~gate_prev_reg;
  assign gated_ready = enable_reg & ~direct_reg;
  assign wake_gate = |(gated_ready & chan_gate & {gate_rise[0], gate_rise[0],
                       gate_rise[1], gate_rise[1], gate_rise[2], gate_rise[2],
                       gate_rise[1], gate_rise[0]});

  // Gate history for edges; wake is one pulse per event
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_prev_reg <= 3'h0;
      wake_reg <= RESET_LOW;
    end else begin
      gate_prev_reg <= gate_level;
      wake_reg <= low_power_mode & (wake_gate | change_irq);
    end
  end
  assign wake_request = wake_reg;

  // Status snapshot is registered so the serial engine sees stable data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      status_reg.comparator_state_bit <= comparator_level;
      status_reg.irq_source_code <= code_next;
      status_reg.source_overtemp <= overtemp_any;
    end
  end
  assign status_word = status_reg;

  // Checks
  ot_all_off_a: assert property (@(posedge core_clk) disable iff (rst)
    overtemp_any |-> source_on == '0) else $error("source on during overtemp");
  inactive_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !active_mode |-> source_on == '0) else $error("source on outside active mode");
  high_side_a: assert property (@(posedge core_clk) disable iff (rst)
    sink_mode[7:3] == 5'h00) else $error("sink on high-side-only channel");
  program_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable |=>
    enable_reg[$past(cmd_word.channel_addr)] == $past(cmd_word.source_enable))
    else $error("addressed channel not loaded");
  slope_update_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && !cmd_word.channel_program_enable |=>
    slope_disable == $past(cmd_word.irq_or_slope) && $stable(enable_reg))
    else $error("global word misapplied");
  slope_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable |=> $stable(slope_disable))
    else $error("slope changed by channel word");
  ot_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    overtemp_any && !cmd_valid |=> $stable(enable_reg))
    else $error("enables lost in overtemp");
  ot_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    ot_rise && !status_read |=> !irq_out_n) else $error("no overtemp irq");
  change_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    change_irq |=> !irq_out_n ##0 code_reg == IRQ_CODE_CHANGE)
    else $error("change not reported");
  read_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !change_irq |=> code_reg == IRQ_CODE_NONE)
    else $error("source code not cleared");
  lp_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    low_power_permitted |-> source_on == '0) else $error("low power with source on");
  gate_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    low_power_mode && wake_gate |=> wake_request) else $error("no gate wake");
  change_cov: cover property (@(posedge core_clk) disable iff (rst) change_irq);
  ot_cov: cover property (@(posedge core_clk) disable iff (rst) ot_rise ##1 !overtemp_any);
  wake_cov: cover property (@(posedge core_clk) disable iff (rst) wake_request);
  halve_cov: cover property (@(posedge core_clk) disable iff (rst)
    current_halve && slope_disable);
  lp_cov: cover property (@(posedge core_clk) disable iff (rst)
    !low_power_permitted ##1 low_power_permitted);

  // Reset values of direction and global bits
  reset_dir_a: assert property (@(posedge core_clk)
    $fell(rst) |-> sink_mode == RESET_BYTE) else $error("direction not cleared by reset");
  reset_glob_a: assert property (@(posedge core_clk)
    $fell(rst) |-> !slope_disable && !current_halve && irq_out_n)
    else $error("global bits not cleared by reset");

  // Command loading; the !rst antecedent keeps reset edges out of $past
  halve_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid |=> current_halve == $past(cmd_word.current_halve))
    else $error("current halve not loaded");
  halve_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !cmd_valid |=> $stable(current_halve))
    else $error("current halve changed without word");
  slope_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !cmd_valid |=> $stable(slope_disable))
    else $error("slope changed without word");
  sink_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable && cmd_word.channel_addr < DIR_CHANNELS |=>
    sink_mode[$past(cmd_word.channel_addr)] == $past(cmd_word.sink_select))
    else $error("direction bit not applied");
  sink_high_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable && cmd_word.channel_addr >= DIR_CHANNELS |=>
    $stable(sink_mode))
    else $error("direction changed by high-side word");
  direct_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable |=>
    direct_reg[$past(cmd_word.channel_addr)] == $past(cmd_word.source_direct_on))
    else $error("direct-on bit not loaded");
  irq_en_load_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_word.channel_program_enable |=>
    irq_en_reg[$past(cmd_word.channel_addr)] == $past(cmd_word.irq_or_slope))
    else $error("irq enable not loaded");
  only_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((enable_reg ^ $past(enable_reg)) & ~$past(load_chan)) == '0)
    else $error("unaddressed channel changed");

  // Drive decision against the configuration table
  direct_on_a: assert property (@(posedge core_clk) disable iff (rst)
    drive_allowed |-> (enable_reg & direct_reg & ~source_on) == '0)
    else $error("direct-on channel not driven");
  gated_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (source_on & (~enable_reg | (~direct_reg & ~chan_gate))) == '0)
    else $error("channel driven while off");
  resume_a: assert property (@(posedge core_clk) disable iff (rst)
    active_mode && !overtemp_any |-> source_on == (enable_reg & (direct_reg | chan_gate)))
    else $error("outputs did not follow configuration");
  lp_permit_a: assert property (@(posedge core_clk) disable iff (rst)
    low_power_permitted == &(~enable_reg | (~direct_reg & ~chan_gate)))
    else $error("low power permission wrong");

  // Status word and interrupt sources
  cmp_status_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> status_word.comparator_state_bit == $past(comparator_level))
    else $error("comparator state not reported");
  ot_status_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> status_word.source_overtemp == $past(overtemp_any))
    else $error("overtemp state not reported");
  status_code_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> status_word.irq_source_code == code_reg)
    else $error("status code differs from source code");
  ot_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !ot_rise |=> !ot_pend_reg) else $error("overtemp request not cleared");
  code_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !status_read && !change_irq |=> $stable(code_reg))
    else $error("source code changed without event");

  // Wake requests only from low power and only on an event
  change_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    low_power_mode && change_irq |=> wake_request) else $error("no change wake");
  wake_mode_a: assert property (@(posedge core_clk) disable iff (rst)
    !low_power_mode |=> !wake_request) else $error("wake outside low power");
  wake_past_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_request |-> $past(low_power_mode)) else $error("wake without low power");
  no_spur_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !wake_gate && !change_irq |=> !wake_request)
    else $error("wake without event");
endmodule

// ### rtl/switch_port_pkg.sv
// Shared constants and carrier types for the switch port current control
package switch_port_pkg;
  localparam int CHANNELS = 8;
  localparam int DIR_CHANNELS = 3;
  localparam int SYNC_STAGES = 3;
  localparam logic RESET_LOW = 1'h0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] IRQ_CODE_NONE = 2'h0;
  localparam logic [1:0] IRQ_CODE_CHANGE = 2'h1;
  localparam logic [2:0] SINK_CAPABLE_MASK = 3'h7;
  localparam int RATIO_FULL = 100;
  localparam int RATIO_HALF = 50;

  // One command word as delivered by the serial engine
  typedef struct packed {
    logic channel_program_enable;
    logic [2:0] channel_addr;
    logic source_enable;
    logic sink_select;
    logic irq_or_slope;
    logic source_direct_on;
    logic current_halve;
  } cmd_word_t;

  // Per-channel configuration as held by the block
  typedef struct packed {
    logic source_enable;
    logic source_direct_on;
    logic sink_select;
    logic channel_irq_enable;
  } chan_cfg_t;

  // Switch-interface part of the status word
  typedef struct packed {
    logic source_overtemp;
    logic [1:0] irq_source_code;
    logic [7:0] comparator_state_bit;
  } status_word_t;
endpackage

// ### rtl/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync
  import switch_port_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_next;

  // Per bit, take the new value only where the last two stages match
  assign agree = ~(stage2_reg ^ stage3_reg);
  assign level_next = (agree & stage3_reg) | (~agree & level_reg);
  assign level_out = level_reg;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
    end
  end
endmodule

// ### rtl/switch_channel.sv
// One switch channel: drive decision and comparator state-change detection
`timescale 1ns/1ps
module switch_channel
  import switch_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire chan_cfg_t cfg,
  input wire logic gate_level,
  input wire logic comparator_level,
  input wire logic drive_allowed,
  output logic source_on,
  output logic output_off,
  output logic state_change
);
  logic trigger;
  logic trigger_reg;
  logic trigger_fall;
  logic sample_reg;
  logic sample_next;
  logic change_reg;

  // Gated mode follows the gate; direct mode is on regardless
  assign trigger = cfg.source_direct_on | gate_level;
  assign output_off = ~cfg.source_enable | ~trigger;
  assign source_on = drive_allowed & ~output_off;

  // Sampling at source switch-off sees a settled comparator
  assign trigger_fall = trigger_reg & ~trigger;
  assign sample_next = trigger_fall ? comparator_level : sample_reg;
  assign state_change = change_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigger_reg <= RESET_LOW;
      sample_reg <= RESET_LOW;
      change_reg <= RESET_LOW;
    end else begin
      trigger_reg <= trigger;
      sample_reg <= sample_next;
      change_reg <= trigger_fall & (comparator_level ^ sample_reg);
    end
  end

  // A change pulse only ever follows a trigger fall
  fall_only_a: assert property (@(posedge core_clk) disable iff (rst)
    !rst && !trigger_fall |=> !change_reg) else $error("change without trigger fall");
endmodule

// ### verification/host_model.sv
// Host-side model: serial command words and the three gate pins
`timescale 1ns/1ps
module host_model
  import switch_port_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_valid,
  output cmd_word_t cmd_word,
  output logic [2:0] gate_pins
);
  // Idle after reset, nothing on the command lines
  initial begin
    cmd_valid = 1'h0;
    cmd_word = '0;
    gate_pins = 3'h0;
  end

  // One word per call; the bus shows the inverse once released so stale data never matches
  task automatic send(input cmd_word_t w);
    @(posedge core_clk);
    cmd_valid <= 1'h1;
    cmd_word <= w;
    @(posedge core_clk);
    cmd_valid <= 1'h0;
    cmd_word <= ~w;
  endtask

  // Gate levels, then time for the synchroniser to settle
  task automatic set_gates(input logic [2:0] g);
    @(posedge core_clk);
    gate_pins <= g;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the switch port current control
`timescale 1ns/1ps
module testbench
  import switch_port_pkg::*;
;
  localparam logic [32:0] MC = 33'h00007FFFF;
  localparam logic [32:0] MI = 33'h040000000;
  localparam logic [32:0] MCODE = 33'h018000000;
  localparam logic [32:0] MCMP = 33'h007F80000;
  localparam logic [32:0] MWK = 33'h180000000;
  localparam logic [32:0] MOT = 33'h020000000;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic status_read = 1'h0;
  logic active_mode = 1'h1;
  logic low_power_mode = 1'h0;
  logic [7:0] comparator_in = 8'h00;
  logic [7:0] overtemp_in = 8'h00;
  logic cmd_valid;
  cmd_word_t cmd_word;
  logic [2:0] gate_pins;
  logic [7:0] source_on, sink_mode;
  logic slope_disable, current_halve, low_power_permitted, wake_request, irq_out_n;
  status_word_t status_word;
  logic [1:0] wake_cnt;
  logic [7:0] en, don, snk;
  logic slope, halve, act, ot, exp_irqn;
  logic [1:0] wk;
  logic [10:0] exp_st;
  logic [65:0] exp_q[$];
  logic [65:0] note;
  logic chk_req = 1'h0;
  logic [31:0] r;
  int fails = 0;
  int check_count = 0;
  wire [32:0] obs = {wake_cnt, irq_out_n, status_word, low_power_permitted, slope_disable,
    current_halve, sink_mode, source_on};

  always #5 core_clk = ~core_clk;

  switch_port_current_control switch_port_current_control_i (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .status_read(status_read),
    .gate_input_one(gate_pins[0]), .gate_input_two(gate_pins[1]),
    .gate_input_three(gate_pins[2]), .comparator_in(comparator_in), .overtemp_in(overtemp_in),
    .active_mode(active_mode), .low_power_mode(low_power_mode), .source_on(source_on),
    .sink_mode(sink_mode), .slope_disable(slope_disable), .current_halve(current_halve),
    .low_power_permitted(low_power_permitted), .wake_request(wake_request),
    .status_word(status_word), .irq_out_n(irq_out_n));
  host_model host_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .gate_pins(gate_pins));

  // Count wake pulses, since a one-cycle pulse is easy to miss at a sample point
  always @(posedge core_clk) begin
    if (rst) wake_cnt <= 2'h0;
    else if (wake_request) wake_cnt <= wake_cnt + 2'h1;
  end

  // Expected outputs from the bench's own view of configuration and pins
  function automatic logic [32:0] mv();
    logic [7:0] g, on;
    g = {gate_pins[0], gate_pins[0], gate_pins[1], gate_pins[1], gate_pins[2], gate_pins[2],
      gate_pins[1], gate_pins[0]};
    on = en & (don | g);
    return {wk, exp_irqn, exp_st, ~|on, slope, halve, {5'h0, snk[2:0] & SINK_CAPABLE_MASK},
      on & {8{act & ~ot}}};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Note the expectation now; the watcher compares it half a cycle after the next edge
  task automatic expect_now(input logic [32:0] m);
    exp_q.push_back({m, mv()});
    @(posedge core_clk);
    chk_req <= 1'h1;
    @(posedge core_clk);
    chk_req <= 1'h0;
  endtask

  // Watcher on the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    if (chk_req) begin
      note = exp_q.pop_front();
      chk(obs & note[65:33], note[32:0] & note[65:33]);
    end
  end

  task automatic prog(input logic [2:0] a, input logic e, s, i, d, h);
    host_model_i.send({1'h1, a, e, s, i, d, h});
    en[a] = e;
    snk[a] = s;
    don[a] = d;
    halve = h;
  endtask

  task automatic glob(input logic sl, input logic h);
    r = $urandom;
    host_model_i.send({1'h0, r[2:0], r[3], r[4], sl, r[5], h});
    slope = sl;
    halve = h;
  endtask

  task automatic read_status();
    @(posedge core_clk);
    status_read <= 1'h1;
    @(posedge core_clk);
    status_read <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic clear_model();
    {en, don, snk, slope, halve, ot, wk} = '0;
    {act, exp_irqn, exp_st} = {1'h1, 1'h1, 11'h000};
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial begin
    clear_model();
    void'($urandom(66));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    expect_now(MI | MCODE | MC);
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      prog(k[2:0], r[0], r[1], 1'h0, r[2], r[3]);
      expect_now(MC);
    end
    for (int k = 0; k < 8; k++) begin
      host_model_i.set_gates(k[2:0]);
      expect_now(MC);
    end
    glob(1'h1, 1'h1);
    expect_now(MC);
    glob(1'h0, 1'h0);
    expect_now(MC);
    @(posedge core_clk);
    active_mode <= 1'h0;
    act = 1'h0;
    expect_now(MC);
    active_mode <= 1'h1;
    act = 1'h1;
    // Overtemp shuts everything down, configuration survives
    prog(3'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    overtemp_in <= 8'h10;
    ot = 1'h1;
    exp_irqn = 1'h0;
    exp_st = 11'h400;
    repeat (6) @(posedge core_clk);
    expect_now(MC | MI | MOT);
    overtemp_in <= 8'h00;
    ot = 1'h0;
    exp_st = 11'h000;
    repeat (6) @(posedge core_clk);
    expect_now(MC | MOT);
    read_status();
    exp_irqn = 1'h1;
    expect_now(MI);
    r = $urandom;
    comparator_in <= r[7:0];
    exp_st = {3'h0, r[7:0]};
    repeat (6) @(posedge core_clk);
    expect_now(MCMP);
    // Fresh reset in mid-run before the state change sequence
    host_model_i.set_gates(3'h0);
    comparator_in <= 8'h00;
    rst <= 1'h1;
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    clear_model();
    prog(3'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    comparator_in <= 8'h01;
    repeat (6) @(posedge core_clk);
    prog(3'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    repeat (4) @(posedge core_clk);
    exp_irqn = 1'h0;
    exp_st = {3'h1, 8'h01};
    expect_now(MI | MCODE | MC);
    read_status();
    exp_irqn = 1'h1;
    exp_st = {3'h0, 8'h01};
    expect_now(MI | MCODE);
    // Gate rise while in low power wakes the device
    low_power_mode <= 1'h1;
    prog(3'h6, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    expect_now(MC | MWK);
    host_model_i.set_gates(3'h1);
    wk = 2'h1;
    expect_now(MC | MWK);
    // Gate fall samples a new comparator level; the change wakes too
    comparator_in <= 8'h00;
    repeat (6) @(posedge core_clk);
    host_model_i.set_gates(3'h0);
    repeat (2) @(posedge core_clk);
    wk = 2'h2;
    exp_irqn = 1'h0;
    exp_st = {3'h1, 8'h00};
    expect_now(MC | MWK | MI | MCODE | MCMP);
    tally_and_finish();
  end
endmodule
